// ===== fault_response_pkg.sv
package fault_response_pkg;

    // register map: each register is one aligned word, its byte address is four times its index
    localparam logic [9:0]  SETTINGS_INDEX    = 10'h092;
    localparam logic [9:0]  STATUS_INDEX      = 10'h094;
    localparam logic [9:0]  CLEAR_INDEX       = 10'h098;
    localparam logic [11:0] SETTINGS_ADDR     = {SETTINGS_INDEX, 2'b00};
    localparam logic [11:0] STATUS_ADDR       = {STATUS_INDEX, 2'b00};
    localparam logic [11:0] CLEAR_ADDR        = {CLEAR_INDEX, 2'b00};
    localparam logic [31:0] SETTINGS_RESET    = 32'h0000_0000;

    // field positions in the settings register
    localparam int THR_LSB     = 19;
    localparam int RESP_LSB    = 15;
    localparam int DEG_LSB     = 12;
    localparam int FLOOR_LSB   = 8;
    localparam int UV_BIT      = 7;
    localparam int CEIL_LSB    = 4;
    localparam int OV_BIT      = 3;
    localparam int RETRY_LSB   = 0;
    localparam int ABSENT_EN_BIT = 28;
    // writable bits: 30..12 and 10..0 (bit 31 and bit 11 are reserved)
    localparam logic [31:0] SETTINGS_MASK = 32'h7fff_f7ff;

    // timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int DEG_UNIT_NS   = 1000;
    localparam int CLK_NS        = 1_000_000_000 / CLK_HZ;
    localparam int DEG_UNIT_CYC  = (DEG_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int RETRY_MS      = 1;
    localparam int RETRY_CYC_DEF = RETRY_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        st_idle    = 3'b000,
        st_run     = 3'b001,
        st_fault   = 3'b011,
        st_wait    = 3'b010,
        st_latched = 3'b110
    } lock_state_type;

    typedef enum logic [1:0] {
        out_drive  = 2'b00,
        out_tri    = 2'b01,
        out_hs     = 2'b10,
        out_ls     = 2'b11
    } bridge_type;

endpackage : fault_response_pkg

// ===== deglitch_filter.sv
`timescale 1ns/1ps
module deglitch_filter (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // raw condition and filter length in units
    input  wire logic       raw_in,
    input  wire logic [2:0] units,
    // filtered condition
    output logic            filt_out
);
    import fault_response_pkg::*;

    // code 7 needs seventy cycles, so six bits would wrap
    logic [6:0] cnt_q;
    logic [6:0] need;

    assign need = 7'(units * DEG_UNIT_CYC);

    // condition must persist for the full time; code 0 passes straight through
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= 7'h00;
            filt_out <= 1'b0;
        end else if (!raw_in) begin
            cnt_q    <= 7'h00;
            filt_out <= 1'b0;
        end else if (cnt_q + 7'h01 >= need) begin
            filt_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 7'h01;
        end
    end

endmodule : deglitch_filter

// ===== fault_response.sv
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - three-bit absent-load current threshold code decoded
// - codes 0,1 latch fault, tristate bridge
// - code 2 latches fault, high-side brake
// - code 3 latches fault, low-side brake
// - codes 4-7 auto clear after retry interval
// - retries over limit latch with chosen output
// - codes 8, A, C disable lock detection
// - deglitch 0 none, else that many microseconds
// - bus voltage floor code, zero means none
// - undervoltage latches or auto clears by bit
// - bus voltage ceiling code, 2.5 V steps
// - overvoltage latches or auto clears by bit
// - retry limit code, zero means unlimited
// - absent-load check only when enabled
module fault_response #(
    parameter int RETRY_CYC = fault_response_pkg::RETRY_CYC_DEF
) (
    // clock and reset
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [11:0]                    paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // sensing, in millivolts and milliamps
    input  wire logic                           current_limit,
    input  wire logic [15:0]                    bus_mv,
    input  wire logic [11:0]                    phase_ma,
    input  wire logic                           motor_running,
    // outputs
    output fault_response_pkg::bridge_type      bridge_mode,
    output logic                                fault_indicator_pin_n,
    output logic                                absent_load_fault
);
    import fault_response_pkg::*;

    logic [31:0]    settings_q;
    lock_state_type state_q;
    logic [31:0]    wait_q;
    logic [4:0]     retries_q;
    logic           uv_q;
    logic           ov_q;
    logic           lock_det;

    logic [2:0] absent_load_current_threshold;
    logic [3:0] current_limit_lock_response;
    logic [2:0] current_limit_lock_filter_time;
    logic [2:0] bus_voltage_floor;
    logic       undervoltage_recovery_select;
    logic [2:0] bus_voltage_ceiling;
    logic       overvoltage_recovery_select;
    logic [2:0] retry_limit;
    logic       absent_load_check_enable;

    assign absent_load_current_threshold  = settings_q[THR_LSB +: 3];
    assign current_limit_lock_response    = settings_q[RESP_LSB +: 4];
    assign current_limit_lock_filter_time = settings_q[DEG_LSB +: 3];
    assign bus_voltage_floor              = settings_q[FLOOR_LSB +: 3];
    assign undervoltage_recovery_select   = settings_q[UV_BIT];
    assign bus_voltage_ceiling            = settings_q[CEIL_LSB +: 3];
    assign overvoltage_recovery_select    = settings_q[OV_BIT];
    assign retry_limit                    = settings_q[RETRY_LSB +: 3];
    assign absent_load_check_enable       = settings_q[ABSENT_EN_BIT];

    // decode tables
    logic [11:0] thr_ma;
    logic [15:0] floor_mv;
    logic [15:0] ceil_mv;
    logic [4:0]  retry_max;
    logic        detect_off;
    logic        auto_mode;
    bridge_type  fault_out;

    always_comb begin
        case (absent_load_current_threshold)
            3'h0, 3'h1: thr_ma = 12'h04b;
            3'h2:       thr_ma = 12'h064;
            3'h3:       thr_ma = 12'h07d;
            3'h4:       thr_ma = 12'h0fa;
            3'h5:       thr_ma = 12'h1f4;
            3'h6:       thr_ma = 12'h2ee;
            default:    thr_ma = 12'h3e8;
        endcase
        case (bus_voltage_floor)
            3'h1:    floor_mv = 16'h1194;
            3'h2:    floor_mv = 16'h1388;
            3'h3:    floor_mv = 16'h157c;
            3'h4:    floor_mv = 16'h1770;
            3'h5:    floor_mv = 16'h1d4c;
            3'h6:    floor_mv = 16'h2710;
            3'h7:    floor_mv = 16'h30d4;
            default: floor_mv = 16'h0000;
        endcase
        case (bus_voltage_ceiling)
            3'h1:    ceil_mv = 16'h4e20;
            3'h2:    ceil_mv = 16'h57e4;
            3'h3:    ceil_mv = 16'h61a8;
            3'h4:    ceil_mv = 16'h6b6c;
            3'h5:    ceil_mv = 16'h7530;
            3'h6:    ceil_mv = 16'h7ef4;
            3'h7:    ceil_mv = 16'h88b8;
            default: ceil_mv = 16'hffff;
        endcase
        case (retry_limit)
            3'h1:    retry_max = 5'h02;
            3'h2:    retry_max = 5'h03;
            3'h3:    retry_max = 5'h05;
            3'h4:    retry_max = 5'h07;
            3'h5:    retry_max = 5'h0a;
            3'h6:    retry_max = 5'h0f;
            3'h7:    retry_max = 5'h14;
            default: retry_max = 5'h00;
        endcase
        detect_off = current_limit_lock_response == 4'h8 ||
                     current_limit_lock_response == 4'ha ||
                     current_limit_lock_response == 4'hc;
        auto_mode  = current_limit_lock_response[3:2] == 2'b01;
        case (current_limit_lock_response)
            4'h2, 4'h6: fault_out = out_hs;
            4'h3, 4'h7: fault_out = out_ls;
            default:    fault_out = out_tri;
        endcase
    end

    deglitch_filter u_deg (
        .pclk     (pclk),
        .presetn  (presetn),
        .raw_in   (current_limit & ~detect_off),
        .units    (current_limit_lock_filter_time),
        .filt_out (lock_det)
    );

    // apb: zero wait states, unmapped addresses answer with an error
    logic mapped;
    assign mapped = paddr == SETTINGS_ADDR || paddr == STATUS_ADDR || paddr == CLEAR_ADDR;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settings_q <= SETTINGS_RESET;
        end else if (psel && penable && pwrite && paddr == SETTINGS_ADDR) begin
            settings_q <= pwdata & SETTINGS_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    SETTINGS_ADDR: prdata <= settings_q;
                    STATUS_ADDR:   prdata <= {21'h000000, retries_q, state_q, ov_q, uv_q, absent_load_fault};
                    default:       prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    logic clear_wr;
    assign clear_wr = psel && penable && pready && pwrite && paddr == CLEAR_ADDR && pwdata[0];

    // bus voltage faults; a new out-of-bounds condition wins over a clear
    logic uv_now;
    logic ov_now;
    assign uv_now = bus_mv < floor_mv;
    assign ov_now = bus_mv > ceil_mv;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_q <= 1'b0;
            ov_q <= 1'b0;
        end else begin
            if (uv_now)
                uv_q <= 1'b1;
            else if (undervoltage_recovery_select || clear_wr)
                uv_q <= 1'b0;
            if (ov_now)
                ov_q <= 1'b1;
            else if (overvoltage_recovery_select || clear_wr)
                ov_q <= 1'b0;
        end
    end

    // absent-load check: running with too little phase current
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            absent_load_fault <= 1'b0;
        end else if (absent_load_check_enable && motor_running && phase_ma < thr_ma) begin
            absent_load_fault <= 1'b1;
        end else if (clear_wr) begin
            absent_load_fault <= 1'b0;
        end
    end

    // current-limit lock state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= st_idle;
            wait_q    <= 32'h0000_0000;
            retries_q <= 5'h00;
        end else begin
            case (state_q)
                st_idle, st_run: begin
                    if (lock_det) begin
                        state_q <= st_fault;
                    end else begin
                        state_q <= motor_running ? st_run : st_idle;
                        if (motor_running)
                            retries_q <= 5'h00;
                    end
                end
                st_fault: begin
                    if (!auto_mode) begin
                        state_q <= st_latched;
                    end else if (retry_max != 5'h00 && retries_q >= retry_max) begin
                        state_q <= st_latched;
                    end else begin
                        state_q   <= st_wait;
                        wait_q    <= 32'h0000_0000;
                        retries_q <= retries_q + 5'h01;
                    end
                end
                st_wait: begin
                    if (wait_q + 32'h1 >= 32'(RETRY_CYC))
                        state_q <= st_idle;
                    else
                        wait_q <= wait_q + 32'h1;
                end
                st_latched: begin
                    if (clear_wr) begin
                        state_q   <= st_idle;
                        retries_q <= 5'h00;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    // bridge held off drive while any fault stands; pin flags only latched lock, voltage and absent-load faults
    logic lock_active;
    assign lock_active = state_q == st_fault || state_q == st_wait || state_q == st_latched;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_mode           <= out_tri;
            fault_indicator_pin_n <= 1'b1;
        end else begin
            if (lock_active)
                bridge_mode <= fault_out;
            else if (uv_q || ov_q || absent_load_fault)
                bridge_mode <= out_tri;
            else
                bridge_mode <= out_drive;
            // auto-retry waits do not flag the pin, latched faults do
            fault_indicator_pin_n <= !(state_q == st_latched || uv_q || ov_q || absent_load_fault);
        end
    end

    a_latch_pin: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == st_latched |=> !fault_indicator_pin_n)
        else $error("latched lock without fault pin");
    a_disable_codes: assert property (@(posedge pclk) disable iff (!presetn)
        detect_off && !lock_active |=> state_q != st_fault)
        else $error("lock raised while detection disabled");
    a_manual_latch: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == st_fault && !auto_mode |=> state_q == st_latched)
        else $error("manual mode did not latch");
    a_hs_brake: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == st_latched && $stable(current_limit_lock_response) && current_limit_lock_response == 4'h2
        |=> bridge_mode == out_hs)
        else $error("high-side brake not applied");
    a_ls_brake: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == st_latched && $stable(current_limit_lock_response) && current_limit_lock_response == 4'h3
        |=> bridge_mode == out_ls)
        else $error("low-side brake not applied");
    a_retry_count: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == st_fault && auto_mode && (retry_max == 5'h00 || retries_q < retry_max)
        |=> state_q == st_wait && retries_q == $past(retries_q) + 5'h01)
        else $error("retry not counted");
    a_retry_limit: assert property (@(posedge pclk) disable iff (!presetn)
        retry_max != 5'h00 |-> retries_q <= retry_max)
        else $error("retries beyond limit");
    a_uv_latch: assert property (@(posedge pclk) disable iff (!presetn)
        uv_now ##1 (!uv_now && !undervoltage_recovery_select && !clear_wr) |=> uv_q)
        else $error("undervoltage did not latch");
    a_ov_auto: assert property (@(posedge pclk) disable iff (!presetn)
        ov_q && !ov_now && overvoltage_recovery_select |=> !ov_q)
        else $error("overvoltage did not auto clear");
    a_absent_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !absent_load_fault && !absent_load_check_enable |=> !absent_load_fault)
        else $error("absent-load fault while check disabled");
    a_clean_run: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == st_run && !lock_det && motor_running |=> retries_q == 5'h00)
        else $error("retry count not reset");

endmodule : fault_response

// ===== motor_stage_model.sv
`timescale 1ns/1ps
module motor_stage_model (
    // clock
    input  wire logic                           pclk,
    // scenario commands from the bench
    input  wire logic                           overload,
    input  wire logic                           run_cmd,
    input  wire logic [11:0]                    load_ma,
    input  wire logic [15:0]                    supply_mv,
    // bridge command from the block
    input  wire fault_response_pkg::bridge_type bridge_mode,
    // sensed values back to the block
    output logic                                current_limit,
    output logic [15:0]                         bus_mv,
    output logic [11:0]                         phase_ma,
    output logic                                motor_running
);
    import fault_response_pkg::*;
    logic driving;
    assign driving = (bridge_mode == out_drive);
    // a bridge that is tristated or braking carries no drive current, so the comparator and the motor drop
    always_ff @(posedge pclk) begin
        current_limit <= overload && driving;
        phase_ma      <= driving ? load_ma : 12'h000;
        motor_running <= run_cmd && driving;
        bus_mv        <= supply_mv;
    end
endmodule : motor_stage_model

// ===== tb_motor_fault_response_config.sv
`timescale 1ns/1ps
module tb_motor_fault_response_config;
    import fault_response_pkg::*;
    typedef struct packed {
        logic [31:0] cfg;
        logic [15:0] mv;
        logic [1:0]  exp;
    } row_type;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        current_limit, motor_running, fault_indicator_pin_n, absent_load_fault;
    logic        overload, run_cmd;
    logic [15:0] bus_mv, supply_mv;
    logic [11:0] phase_ma, load_ma;
    bridge_type  bridge_mode;
    int          failures, checks_done, cycles;
    row_type     rows[30];
    int          floor_mv[8]  = '{0, 4500, 5000, 5500, 6000, 7500, 10000, 12500};
    int          thr_ma[8]    = '{75, 75, 100, 125, 250, 500, 750, 1000};
    int          limit_tab[8] = '{0, 2, 3, 5, 7, 10, 15, 20};

    fault_response #(.RETRY_CYC(20)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .current_limit(current_limit), .bus_mv(bus_mv), .phase_ma(phase_ma),
        .motor_running(motor_running), .bridge_mode(bridge_mode),
        .fault_indicator_pin_n(fault_indicator_pin_n), .absent_load_fault(absent_load_fault));
    motor_stage_model i_stage (
        .pclk(pclk), .overload(overload), .run_cmd(run_cmd), .load_ma(load_ma),
        .supply_mv(supply_mv), .bridge_mode(bridge_mode), .current_limit(current_limit),
        .bus_mv(bus_mv), .phase_ma(phase_ma), .motor_running(motor_running));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // generous ceiling: the whole sequence needs well under 10000 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            conclude();
        end
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // request held until pready is sampled high; only the bench timeout ends the wait
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task wait_state(input logic [2:0] s);
        int n;
        n = 0;
        rd(STATUS_ADDR);
        while (rdv[5:3] !== s && n < 300) begin
            rd(STATUS_ADDR);
            n++;
        end
        check("lock_state", rdv[5:3], s);
    endtask : wait_state

    function automatic bridge_type exp_bridge(input int c);
        return (c % 4 < 2) ? out_tri : ((c % 4 == 2) ? out_hs : out_ls);
    endfunction : exp_bridge

    task clear_all();
        overload <= 1'b0;
        load_ma  <= 12'h7ff;
        // stop the motor so the lock state settles back to idle
        run_cmd  <= 1'b0;
        repeat (3) @(posedge pclk);
        wr(CLEAR_ADDR, 32'h0000_0001);
        rd(STATUS_ADDR);
        check("cleared", rdv[5:3], 3'b000);
        check("pin_released", fault_indicator_pin_n, 1'b1);
    endtask : clear_all

    task latch_case(input logic [31:0] cfg, input logic [15:0] bad, input int bit_idx);
        wr(SETTINGS_ADDR, cfg);
        supply_mv <= bad;
        repeat (4) @(posedge pclk);
        supply_mv <= 16'd12000;
        repeat (4) @(posedge pclk);
        rd(STATUS_ADDR);
        check("volt_latched", rdv[bit_idx], 1'b1);
        check("volt_pin", fault_indicator_pin_n, 1'b0);
        clear_all();
        rd(STATUS_ADDR);
        check("volt_cleared", rdv[bit_idx], 1'b0);
    endtask : latch_case

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        overload = 1'b0;
        run_cmd = 1'b0;
        load_ma = 12'h7ff;
        supply_mv = 16'd12000;
        for (int c = 1; c < 8; c++) begin
            rows[4*c-4] = '{(c << FLOOR_LSB) | 32'h88, 16'(floor_mv[c] - 1), 2'b01};
            rows[4*c-3] = '{(c << FLOOR_LSB) | 32'h88, 16'(floor_mv[c]), 2'b00};
            rows[4*c-2] = '{(c << CEIL_LSB) | 32'h88, 16'(20000 + 2500 * (c - 1)), 2'b00};
            rows[4*c-1] = '{(c << CEIL_LSB) | 32'h88, 16'(20001 + 2500 * (c - 1)), 2'b10};
        end
        rows[28] = '{32'h88, 16'h0000, 2'b00};
        rows[29] = '{32'h88, 16'hffff, 2'b00};
        repeat (2) @(posedge pclk);
        check("reset_pin", fault_indicator_pin_n, 1'b1);
        check("reset_bridge", bridge_mode, out_tri);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(SETTINGS_ADDR);
        check("settings_reset", rdv, SETTINGS_RESET);
        wr(SETTINGS_ADDR, 32'hffff_ffff);
        rd(SETTINGS_ADDR);
        check("settings_mask", rdv, SETTINGS_MASK);
        wr(12'h010, 32'hffff_ffff);
        check("unmapped_wr_err", err, 1'b1);
        rd(12'h010);
        check("unmapped_rd_err", err, 1'b1);
        check("unmapped_rd", rdv, 32'h0000_0000);
        $display("test registers done");
        for (int i = 0; i < 30; i++) begin
            wr(SETTINGS_ADDR, rows[i].cfg);
            supply_mv <= rows[i].mv;
            repeat (4) @(posedge pclk);
            rd(STATUS_ADDR);
            check("volt_flags", rdv[2:1], rows[i].exp);
        end
        supply_mv <= 16'd12000;
        latch_case(32'h1 << FLOOR_LSB, 16'd4000, 1);
        latch_case(32'h1 << CEIL_LSB, 16'd21000, 2);
        $display("test voltage done");
        for (int c = 0; c < 4; c++) begin
            wr(SETTINGS_ADDR, (c << RESP_LSB) | ((2 * c + 1) << DEG_LSB));
            overload <= 1'b1;
            repeat ((2 * c + 1) * 10 - 3) @(posedge pclk);
            overload <= 1'b0;
            repeat (5) @(posedge pclk);
            rd(STATUS_ADDR);
            check("glitch_ignored", rdv[4], 1'b0);
            overload <= 1'b1;
            wait_state(3'b110);
            check("latched_bridge", bridge_mode, exp_bridge(c));
            check("latched_pin", fault_indicator_pin_n, 1'b0);
            repeat (30) @(posedge pclk);
            check("bridge_held", bridge_mode, exp_bridge(c));
            clear_all();
        end
        $display("test latched lock done");
        for (int c = 4; c < 8; c++) begin
            wr(SETTINGS_ADDR, (c << RESP_LSB) | (c - 3));
            overload <= 1'b1;
            wait_state(3'b010);
            check("retry_pin", fault_indicator_pin_n, 1'b1);
            wait_state(3'b110);
            check("retry_bridge", bridge_mode, exp_bridge(c));
            check("retry_pin_latched", fault_indicator_pin_n, 1'b0);
            check("retry_count", rdv[10:6], limit_tab[c-3]);
            clear_all();
        end
        wr(SETTINGS_ADDR, 32'h4 << RESP_LSB);
        overload <= 1'b1;
        repeat (400) @(posedge pclk);
        rd(STATUS_ADDR);
        check("unlimited", rdv[5:3] == 3'b110, 1'b0);
        overload <= 1'b0;
        run_cmd  <= 1'b1;
        repeat (60) @(posedge pclk);
        rd(STATUS_ADDR);
        check("count_reset", rdv[10:6], 5'h00);
        $display("test auto retry done");
        for (int c = 8; c < 13; c += 2) begin
            wr(SETTINGS_ADDR, c << RESP_LSB);
            overload <= 1'b1;
            repeat (50) @(posedge pclk);
            rd(STATUS_ADDR);
            check("disabled_state", rdv[4], 1'b0);
            check("disabled_out", {fault_indicator_pin_n, bridge_mode}, {1'b1, out_drive});
            overload <= 1'b0;
        end
        $display("test disabled lock done");
        wr(SETTINGS_ADDR, 32'h7 << THR_LSB);
        load_ma <= 12'h000;
        repeat (5) @(posedge pclk);
        check("absent_off", absent_load_fault, 1'b0);
        for (int t = 0; t < 8; t++) begin
            for (int k = 0; k < 2; k++) begin
                wr(SETTINGS_ADDR, (32'h1 << ABSENT_EN_BIT) | (t << THR_LSB));
                load_ma <= 12'(thr_ma[t] - 1 + k);
                run_cmd <= 1'b1;
                repeat (5) @(posedge pclk);
                check("absent_load", absent_load_fault, k == 0);
                clear_all();
            end
        end
        $display("test absent load done");
        wr(SETTINGS_ADDR, 32'h1 << ABSENT_EN_BIT);
        load_ma <= 12'h000;
        run_cmd <= 1'b1;
        repeat (5) @(posedge pclk);
        check("pre_reset_fault", absent_load_fault, 1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("midrun_fault", absent_load_fault, 1'b0);
        check("midrun_pin", fault_indicator_pin_n, 1'b1);
        check("midrun_bridge", bridge_mode, out_tri);
        presetn <= 1'b1;
        rd(SETTINGS_ADDR);
        check("midrun_settings", rdv, SETTINGS_RESET);
        repeat (3) @(posedge pclk);
        check("midrun_no_refault", absent_load_fault, 1'b0);
        run_cmd <= 1'b0;
        $display("test mid-run reset done");
        conclude();
    end
endmodule : tb_motor_fault_response_config
